// ==== rtl/sslsup_consts.svh ====
// Constants for the serial slave link supervisor
// Assumes a 10 MHz system clock; included by bare name
`ifndef SSLSUP_CONSTS_SVH
`define SSLSUP_CONSTS_SVH
`define SSLSUP_CLK_HZ        10000000
`define SSLSUP_ADDR_MAX      8'hC7
`define SSLSUP_ADDR_ALIAS    8'hFF
`define SSLSUP_REG_FREE_LO   16'h0004
`define SSLSUP_REG_FREE_HI   16'h0005
`define SSLSUP_GAP_MAX       7'h63
`define SSLSUP_BITS_PER_CHAR 11
`define SSLSUP_SEC_CYCLES    (`SSLSUP_CLK_HZ)
`endif

// ==== rtl/sslsup_pkg.sv ====
// Types for the serial slave link supervisor
// Assumes sslsup_consts.svh is compiled alongside
package sslsup_pkg;
  typedef enum logic [2:0] {
    SSLSUP_B1200, SSLSUP_B2400, SSLSUP_B4800, SSLSUP_B9600,
    SSLSUP_B19200, SSLSUP_B38400, SSLSUP_B57600, SSLSUP_B115200
  } sslsup_baud_e;
  typedef enum logic [2:0] {
    SSLSUP_RSP_STD, SSLSUP_RSP_10, SSLSUP_RSP_20, SSLSUP_RSP_50,
    SSLSUP_RSP_100, SSLSUP_RSP_200
  } sslsup_pause_e;
  typedef enum logic [1:0] {
    SSLSUP_AO_OFF, SSLSUP_AO_SCALED, SSLSUP_AO_LINK
  } sslsup_aomode_e;
endpackage

// ==== rtl/sslsup_down_counter.sv ====
// Loadable down counter with a terminal flag
// Assumes one clock, synchronous reset, clock enable
`timescale 1ns/1ns
`default_nettype none
module sslsup_down_counter #(
  parameter int W = 24
) (
  // Clocking
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         clkEn,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  input  wire logic         step,
  // Status
  output logic              isZero
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Next count
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = loadVal;
    end else if (step && cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  // Count register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (clkEn) begin
      cnt_q <= cnt_d;
    end
  end

  assign isZero = (cnt_q == '0);
endmodule
`default_nettype wire

// ==== rtl/sslsup_top.sv ====
// Serial slave link supervisor: address match, write permit, gap watchdog, reply pause
// Assumes a frame decoder upstream that flags complete valid frames and their fields
// Summary of operation
// RQ1: Station address accepted only 0..199; frames with that address are answered.
// RQ2: With address zero, answer frames addressed to 255 instead.
// RQ3: Line rate selectable among eight settings from 1200 to 115200 baud.
// RQ4: Write permit off refuses configuration register writes from the master.
// RQ5: Registers 04h and 05h stay writable whatever the permit setting.
// RQ6: Gap beyond limit forces link-driven relays and analogue output to alert.
// RQ7: Gap limit 0..99 seconds; zero disables supervision.
// RQ8: Standard reply setting answers with no added delay.
// RQ9: Other settings add 10, 20, 50, 100 or 200 character times.
// RQ10: Master side should pick pauses 10/20/50 for fast marginal converters.
// RQ11: When the fault clears, link-mode analogue output returns to its link value; scaled mode never alerts.
// RQ12: Gap timer restarts per valid frame (code: only frames matching the station address); pause counts from request end.
`timescale 1ns/1ns
`default_nettype none
`include "sslsup_consts.svh"
module sslsup_top
  import sslsup_pkg::*;
#(
  parameter int SEC_CYCLES = `SSLSUP_SEC_CYCLES  // Clock cycles per watchdog second
) (
  // Clocking
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  // Configuration
  input  wire logic [7:0]  stationAddr,
  input  wire logic [2:0]  baudSel,
  input  wire logic        configWritePermit,
  input  wire logic [6:0]  frameGapLimit,
  input  wire logic [2:0]  replyPauseSetting,
  input  wire logic [1:0]  analogOutputMode,
  // Received frame
  input  wire logic        frameDone,
  input  wire logic [7:0]  frameAddr,
  input  wire logic        frameIsWrite,
  input  wire logic [15:0] frameReg,
  // Relay and analogue sources
  input  wire logic [1:0]  relayLinkCmd,
  input  wire logic [1:0]  relayLinkCtl,
  input  wire logic [1:0]  relayAlertLvl,
  input  wire logic [15:0] analogScaled,
  input  wire logic [15:0] analogLink,
  input  wire logic [15:0] analogAlert,
  // Results
  output logic             addrValid,
  output logic [15:0]      baudDivisor,
  output logic             frameAccept,
  output logic             writeRefused,
  output logic             replyGo,
  output logic             linkAlert,
  output logic [1:0]       relayOut,
  output logic [15:0]      analogOut
);
  // ----------------------------------------------------------------
  // Address and line rate decode
  // ----------------------------------------------------------------
  logic        addrOk;
  logic [7:0]  matchAddr;
  logic [15:0] bitCycles;
  // Address range and alias
  always_comb begin
    addrOk    = (stationAddr <= `SSLSUP_ADDR_MAX);            // RQ1
    matchAddr = (stationAddr == 8'h00) ? `SSLSUP_ADDR_ALIAS   // RQ2
                                       : stationAddr;
  end

  // Clock cycles per bit for each rate
  always_comb begin
    case (sslsup_baud_e'(baudSel))                            // RQ3
      SSLSUP_B1200:   bitCycles = 16'(`SSLSUP_CLK_HZ / 1200);
      SSLSUP_B2400:   bitCycles = 16'(`SSLSUP_CLK_HZ / 2400);
      SSLSUP_B4800:   bitCycles = 16'(`SSLSUP_CLK_HZ / 4800);
      SSLSUP_B9600:   bitCycles = 16'(`SSLSUP_CLK_HZ / 9600);
      SSLSUP_B19200:  bitCycles = 16'(`SSLSUP_CLK_HZ / 19200);
      SSLSUP_B38400:  bitCycles = 16'(`SSLSUP_CLK_HZ / 38400);
      SSLSUP_B57600:  bitCycles = 16'(`SSLSUP_CLK_HZ / 57600);
      SSLSUP_B115200: bitCycles = 16'(`SSLSUP_CLK_HZ / 115200);
      default:        bitCycles = 16'(`SSLSUP_CLK_HZ / 9600);
    endcase
  end

  // ----------------------------------------------------------------
  // Frame acceptance and write permission
  // ----------------------------------------------------------------
  logic hit;
  logic freeReg;
  logic refuse;
  logic accept_d;
  logic accept_q;
  logic refused_d;
  logic refused_q;
  // Frame qualification
  always_comb begin
    hit       = frameDone && addrOk && (frameAddr == matchAddr);  // RQ1
    freeReg   = (frameReg == `SSLSUP_REG_FREE_LO) ||
                (frameReg == `SSLSUP_REG_FREE_HI);                // RQ5
    refuse    = hit && frameIsWrite && !configWritePermit && !freeReg; // RQ4
    accept_d  = hit && !refuse;
    refused_d = refuse;
  end

  // Acceptance pulses
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      accept_q  <= 1'b0;
      refused_q <= 1'b0;
    end else if (clkEn) begin
      accept_q  <= accept_d;
      refused_q <= refused_d;
    end
  end

  // ----------------------------------------------------------------
  // Reply pause
  // ----------------------------------------------------------------
  logic [7:0]  pauseChars;
  logic        pending_q;
  logic        pending_d;
  logic        bitZero;
  logic        charZero;
  logic [3:0]  bitIdx_q;
  logic [3:0]  bitIdx_d;
  logic        charTick;
  logic        go_d;
  logic        go_q;

  // Character count per setting
  always_comb begin
    case (sslsup_pause_e'(replyPauseSetting))
      SSLSUP_RSP_STD: pauseChars = 8'h00;                     // RQ8
      SSLSUP_RSP_10:  pauseChars = 8'h0A;                     // RQ9
      SSLSUP_RSP_20:  pauseChars = 8'h14;
      SSLSUP_RSP_50:  pauseChars = 8'h32;
      SSLSUP_RSP_100: pauseChars = 8'h64;
      SSLSUP_RSP_200: pauseChars = 8'hC8;
      default:        pauseChars = 8'h00;
    endcase
  end

  // Bit timer, reloaded each bit
  sslsup_down_counter #(.W(16)) u_bitTimer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .load    (bitZero || hit),
    .loadVal (bitCycles - 16'h0001),
    .step    (1'b1),
    .isZero  (bitZero)
  );

  // Bits within a character
  always_comb begin
    bitIdx_d = bitIdx_q;
    charTick = 1'b0;
    if (hit) begin
      bitIdx_d = 4'h0;
    end else if (bitZero) begin
      if (bitIdx_q == 4'(`SSLSUP_BITS_PER_CHAR - 1)) begin
        bitIdx_d = 4'h0;
        charTick = 1'b1;
      end else begin
        bitIdx_d = bitIdx_q + 4'h1;
      end
    end
  end
  // Bit index register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bitIdx_q <= 4'h0;
    end else if (clkEn) begin
      bitIdx_q <= bitIdx_d;
    end
  end

  // Character countdown from end of request
  sslsup_down_counter #(.W(8)) u_charTimer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .load    (accept_d),                                      // RQ12
    .loadVal (pauseChars),
    .step    (charTick),
    .isZero  (charZero)
  );

  // Reply release
  always_comb begin
    pending_d = pending_q;
    go_d      = 1'b0;
    if (accept_d) begin
      pending_d = 1'b1;
    end else if (pending_q && charZero) begin
      pending_d = 1'b0;
      go_d      = 1'b1;                                       // RQ8
    end
  end
  // Pending and release registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pending_q <= 1'b0;
      go_q      <= 1'b0;
    end else if (clkEn) begin
      pending_q <= pending_d;
      go_q      <= go_d;
    end
  end

  // ----------------------------------------------------------------
  // Frame gap watchdog
  // ----------------------------------------------------------------
  logic       secZero;
  logic [6:0] secs_q;
  logic [6:0] secs_d;
  logic       alert_d;
  logic       alert_q;
  logic [6:0] limit;

  // Second prescaler, restarted per frame addressed to this station
  sslsup_down_counter #(.W(24)) u_secTimer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .load    (secZero || hit),                                // RQ12
    .loadVal (24'(SEC_CYCLES - 1)),
    .step    (1'b1),
    .isZero  (secZero)
  );

  // Elapsed seconds and alert
  always_comb begin
    limit   = (frameGapLimit > `SSLSUP_GAP_MAX) ? `SSLSUP_GAP_MAX : frameGapLimit; // RQ7
    secs_d  = secs_q;
    alert_d = alert_q;
    if (hit) begin
      secs_d  = 7'h00;                                        // RQ12
      alert_d = 1'b0;                                         // RQ11
    end else if (secZero && secs_q != 7'h7F) begin
      secs_d = secs_q + 7'h01;
    end
    if (limit == 7'h00) begin
      alert_d = 1'b0;                                         // RQ7
    end else if (secs_q >= limit && secZero) begin            // Timeout wins over a same-cycle frame
      alert_d = 1'b1;                                         // RQ6
    end
  end
  // Seconds and alert registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      secs_q  <= 7'h00;
      alert_q <= 1'b0;
    end else if (clkEn) begin
      secs_q  <= secs_d;
      alert_q <= alert_d;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic [1:0]  relay_d;
  logic [15:0] analog_d;

  // Relay and analogue selection
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      relay_d[i] = relayLinkCmd[i];
      if (relayLinkCtl[i] && alert_d) begin
        relay_d[i] = relayAlertLvl[i];                        // RQ6
      end
    end
    case (sslsup_aomode_e'(analogOutputMode))
      SSLSUP_AO_LINK:   analog_d = alert_d ? analogAlert : analogLink; // RQ6
      SSLSUP_AO_SCALED: analog_d = analogScaled;              // RQ11
      default:          analog_d = 16'h0000;
    endcase
  end
  // Result registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addrValid   <= 1'b0;
      baudDivisor <= 16'h0000;
      relayOut    <= 2'h0;
      analogOut   <= 16'h0000;
    end else if (clkEn) begin
      addrValid   <= addrOk;
      baudDivisor <= bitCycles;
      relayOut    <= relay_d;
      analogOut   <= analog_d;
    end
  end

  assign frameAccept  = accept_q;
  assign writeRefused = refused_q;
  assign replyGo      = go_q;
  assign linkAlert    = alert_q;
endmodule
`default_nettype wire

// ==== test/sslsup_properties.sv ====
// Checker on the link supervisor top ports
// Assumes a bind from the testbench top file
`timescale 1ns/1ns
`default_nettype none
module sslsup_properties (
  // Clocking
  input wire logic        clock,
  input wire logic        sys_rst,
  // Configuration
  input wire logic [7:0]  stationAddr,
  input wire logic        configWritePermit,
  input wire logic [6:0]  frameGapLimit,
  input wire logic [2:0]  replyPauseSetting,
  // Frame
  input wire logic        frameDone,
  input wire logic [7:0]  frameAddr,
  input wire logic        frameIsWrite,
  input wire logic [15:0] frameReg,
  // Results
  input wire logic        addrValid,
  input wire logic        frameAccept,
  input wire logic        writeRefused,
  input wire logic        replyGo,
  input wire logic        linkAlert
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Frame classification
  logic hit;
  logic free;
  logic wrOk;
  assign hit  = (stationAddr <= 8'hC7) && (frameAddr == ((stationAddr == 8'h00) ? 8'hFF : stationAddr));
  assign free = (frameReg == 16'h0004) || (frameReg == 16'h0005);
  assign wrOk = !frameIsWrite || configWritePermit || free;
  // --------------------------------
  // Properties
  // --------------------------------
  property p_accept; frameDone && hit && wrOk |=> frameAccept && !writeRefused; endproperty
  a_accept: assert property (p_accept) else $error("matched frame not accepted");
  property p_miss; frameDone && !hit |=> !frameAccept && !writeRefused; endproperty
  a_miss: assert property (p_miss) else $error("unmatched frame acted on");
  property p_valid; !$past(sys_rst) |-> addrValid == ($past(stationAddr) <= 8'hC7); endproperty
  a_valid: assert property (p_valid) else $error("address range flag wrong");
  property p_alias;
    frameDone && stationAddr == 8'h00 && frameAddr == 8'hFF && !frameIsWrite |=> frameAccept;
  endproperty
  a_alias: assert property (p_alias) else $error("alias address not answered");
  property p_refuse; frameDone && hit && !wrOk |=> writeRefused && !frameAccept ##1 !replyGo; endproperty
  a_refuse: assert property (p_refuse) else $error("forbidden write not refused");
  property p_free; frameDone && hit && frameIsWrite && free |=> frameAccept; endproperty
  a_free: assert property (p_free) else $error("free register write refused");
  property p_std; frameAccept && replyPauseSetting == 3'h0 |=> replyGo; endproperty
  a_std: assert property (p_std) else $error("standard reply delayed");
  property p_pause; frameAccept && replyPauseSetting inside {[3'h1:3'h5]} |=> (!replyGo) [*8]; endproperty
  a_pause: assert property (p_pause) else $error("paused reply came early");
  property p_gapoff; frameGapLimit == 7'h00 |=> !linkAlert; endproperty
  a_gapoff: assert property (p_gapoff) else $error("alert with supervision off");
  // Main scenarios reached
  c_std: cover property (frameAccept && replyPauseSetting == 3'h0);
  c_ref: cover property (writeRefused);
  c_alias: cover property (frameAccept && stationAddr == 8'h00);
  c_alert: cover property ($rose(linkAlert));
endmodule
`default_nettype wire

// ==== test/sslsup_master_model.sv ====
// Bus master model: delivers decoded frames
// Assumes the caller runs off the falling edge
`timescale 1ns/1ns
`default_nettype none
module sslsup_master_model (
  // Clocking
  input wire logic   clock,
  // Frame
  output logic        frameDone,
  output logic [7:0]  frameAddr,
  output logic        frameIsWrite,
  output logic [15:0] frameReg
);
  // Idle bus
  initial begin
    frameDone = 1'b0;
    frameAddr = 8'h00;
    frameIsWrite = 1'b0;
    frameReg = 16'h0000;
  end
  // One frame end strobe, fields scrambled after
  task automatic send(input logic [7:0] a, input logic w, input logic [15:0] r);
    @(negedge clock);
    frameDone = 1'b1;
    frameAddr = a;
    frameIsWrite = w;
    frameReg = r;
    @(negedge clock);
    frameDone = 1'b0;
    frameAddr = ~a;
    frameIsWrite = ~w;
    frameReg = ~r;
  endtask
endmodule
`default_nettype wire

// ==== test/serial_slave_link_supervisor_test.sv ====
// Self-checking bench of the link supervisor
// Assumes the design package and model compiled first
`timescale 1ns/1ns
`default_nettype none
module serial_slave_link_supervisor_test;
  import sslsup_pkg::*;
  logic clock, sys_rst, clkEn, configWritePermit, frameDone, frameIsWrite;
  logic addrValid, frameAccept, writeRefused, replyGo, linkAlert;
  logic [7:0] stationAddr, frameAddr;
  logic [2:0] baudSel, replyPauseSetting;
  logic [6:0] frameGapLimit;
  logic [1:0] analogOutputMode, relayLinkCmd, relayLinkCtl, relayAlertLvl, relayOut;
  logic [15:0] frameReg, analogScaled, analogLink, analogAlert, baudDivisor, analogOut;
  logic [15:0] div [8] = '{16'h208D, 16'h1046, 16'h0823, 16'h0411, 16'h0208, 16'h0104, 16'h00AD, 16'h0056};
  int error_cnt = 0;
  int cmp_count = 0;
  sslsup_top #(.SEC_CYCLES(500)) sslsup_top_i (
    .clock(clock), .sys_rst(sys_rst), .clkEn(clkEn), .stationAddr(stationAddr),
    .baudSel(baudSel), .configWritePermit(configWritePermit), .frameGapLimit(frameGapLimit),
    .replyPauseSetting(replyPauseSetting), .analogOutputMode(analogOutputMode), .frameDone(frameDone),
    .frameAddr(frameAddr), .frameIsWrite(frameIsWrite), .frameReg(frameReg), .relayLinkCmd(relayLinkCmd),
    .relayLinkCtl(relayLinkCtl), .relayAlertLvl(relayAlertLvl), .analogScaled(analogScaled),
    .analogLink(analogLink), .analogAlert(analogAlert), .addrValid(addrValid), .baudDivisor(baudDivisor),
    .frameAccept(frameAccept), .writeRefused(writeRefused), .replyGo(replyGo), .linkAlert(linkAlert),
    .relayOut(relayOut), .analogOut(analogOut));
  sslsup_master_model sslsup_master_model_i (.clock(clock), .frameDone(frameDone), .frameAddr(frameAddr),
    .frameIsWrite(frameIsWrite), .frameReg(frameReg));
  // Clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One frame with its expected answer
  task automatic frm(input logic [7:0] a, input logic w, input logic [15:0] r, input logic acc, input logic rf);
    sslsup_master_model_i.send(a, w, r);
    chk("frameAccept", {15'h0000, acc}, {15'h0000, frameAccept});
    chk("writeRefused", {15'h0000, rf}, {15'h0000, writeRefused});
    @(negedge clock);
    chk("replyGo", {15'h0000, acc}, {15'h0000, replyGo});
    @(negedge clock);
  endtask
  // Reply pause of n characters at divisor d
  task automatic pause(input logic [2:0] s, input logic [2:0] b, input int n, input int d);
    int k;
    k = 0;
    replyPauseSetting = s;
    baudSel = b;
    repeat (3) @(negedge clock);
    sslsup_master_model_i.send(8'h05, 1'b0, 16'h0001);
    while (replyGo !== 1'b1 && k < n * 11 * d + 3000) begin
      @(negedge clock);
      k++;
    end
    cmp_count++;
    if (k < (n - 1) * 11 * d || k > (n + 1) * 11 * d) begin
      error_cnt++;
      $display("ERROR replyPause expected %0d seen %0d", n * 11 * d, k);
    end
  endtask
  // Verdict
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    {sys_rst, clkEn, stationAddr, baudSel, configWritePermit} = {1'b1, 1'b1, 8'h05, 3'h0, 1'b0};
    {frameGapLimit, replyPauseSetting, analogOutputMode} = {7'h00, 3'h0, 2'h1};
    {relayLinkCmd, relayLinkCtl, relayAlertLvl} = {2'h1, 2'h2, 2'h3};
    {analogScaled, analogLink, analogAlert} = {16'h1234, 16'h5678, 16'h9ABC};
    repeat (20) @(negedge clock);
    chk("analogOut", 16'h0000, analogOut);
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      baudSel = i[2:0];
      repeat (2) @(negedge clock);
      chk("baudDivisor", div[i], baudDivisor);
    end
    // Clock enable low holds the baud divisor register
    clkEn = 1'b0;
    baudSel = 3'h0;
    repeat (3) @(negedge clock);
    chk("baudDivisor", div[7], baudDivisor);
    clkEn = 1'b1;
    repeat (2) @(negedge clock);
    chk("baudDivisor", div[0], baudDivisor);
    chk("addrValid", 16'h0001, {15'h0000, addrValid});
    chk("analogOut", 16'h1234, analogOut);
    chk("linkAlert", 16'h0000, {15'h0000, linkAlert});
    frm(8'h05, 1'b0, 16'h0001, 1'b1, 1'b0);
    frm(8'h06, 1'b0, 16'h0001, 1'b0, 1'b0);
    frm(8'hFF, 1'b0, 16'h0001, 1'b0, 1'b0);
    stationAddr = 8'hC8;
    repeat (2) @(negedge clock);
    chk("addrValid", 16'h0000, {15'h0000, addrValid});
    frm(8'hC8, 1'b0, 16'h0001, 1'b0, 1'b0);
    stationAddr = 8'h00;
    frm(8'hFF, 1'b0, 16'h0001, 1'b1, 1'b0);
    frm(8'h00, 1'b0, 16'h0001, 1'b0, 1'b0);
    stationAddr = 8'h05;
    frm(8'h05, 1'b1, 16'h0003, 1'b0, 1'b1);
    frm(8'h05, 1'b1, 16'h0004, 1'b1, 1'b0);
    frm(8'h05, 1'b1, 16'h0005, 1'b1, 1'b0);
    configWritePermit = 1'b1;
    frm(8'h05, 1'b1, 16'h0003, 1'b1, 1'b0);
    // Gap watchdog, 2 s limit, link-driven analogue output
    analogOutputMode = 2'h2;
    frameGapLimit = 7'h02;
    frm(8'h05, 1'b0, 16'h0001, 1'b1, 1'b0);
    frm(8'h05, 1'b0, 16'h0001, 1'b1, 1'b0);
    repeat (990) @(negedge clock);
    chk("linkAlert", 16'h0000, {15'h0000, linkAlert});
    chk("relayOut", 16'h0001, {14'h0000, relayOut});
    chk("analogOut", 16'h5678, analogOut);
    repeat (520) @(negedge clock);
    chk("linkAlert", 16'h0001, {15'h0000, linkAlert});
    chk("relayOut", 16'h0003, {14'h0000, relayOut});
    chk("analogOut", 16'h9ABC, analogOut);
    frm(8'h05, 1'b0, 16'h0001, 1'b1, 1'b0);
    chk("linkAlert", 16'h0000, {15'h0000, linkAlert});
    chk("relayOut", 16'h0001, {14'h0000, relayOut});
    chk("analogOut", 16'h5678, analogOut);
    repeat (1510) @(negedge clock);
    chk("linkAlert", 16'h0001, {15'h0000, linkAlert});
    frameGapLimit = 7'h00;
    repeat (2) @(negedge clock);
    chk("linkAlert", 16'h0000, {15'h0000, linkAlert});
    repeat (1510) @(negedge clock);
    chk("linkAlert", 16'h0000, {15'h0000, linkAlert});
    analogOutputMode = 2'h0;
    repeat (2) @(negedge clock);
    chk("analogOut", 16'h0000, analogOut);
    pause(3'h1, 3'h5, 10, 260);
    pause(3'h2, 3'h6, 20, 173);
    final_report;
  end
  // Hang guard
  initial begin
    #9000000;
    error_cnt++;
    final_report;
  end
endmodule
bind sslsup_top sslsup_properties sslsup_properties_i (.clock(clock), .sys_rst(sys_rst),
  .stationAddr(stationAddr), .configWritePermit(configWritePermit), .frameGapLimit(frameGapLimit),
  .replyPauseSetting(replyPauseSetting), .frameDone(frameDone), .frameAddr(frameAddr),
  .frameIsWrite(frameIsWrite), .frameReg(frameReg), .addrValid(addrValid), .frameAccept(frameAccept),
  .writeRefused(writeRefused), .replyGo(replyGo), .linkAlert(linkAlert));
`default_nettype wire
